// ==== hdl/fault_status_pkg.sv ====
// Purpose: constants and carrier types for the fault status and interrupt block
// Assumes: byte-wide registers on a 16-bit register address
// Notes: bit positions are shared by live, sticky and mask registers
package fault_status_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [15:0] FAULT_LIVE_STATUS_OFS = 16'h000C;
	localparam logic [15:0] INPUT_LOSS_LIVE_STATUS_OFS = 16'h000D;
	localparam logic [15:0] FAULT_STICKY_FLAGS_OFS = 16'h0011;
	localparam logic [15:0] INPUT_LOSS_STICKY_FLAGS_OFS = 16'h0012;
	localparam logic [15:0] FAULT_INTERRUPT_MASKS_OFS = 16'h0017;
	localparam logic [15:0] INPUT_LOSS_INTERRUPT_MASKS_OFS = 16'h0018;
	localparam logic [15:0] REF_SELECT_CTRL_OFS = 16'h0021;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CALIBRATION_ACTIVE_BIT = 0;
	localparam int CRYSTAL_SIGNAL_LOSS_BIT = 1;
	localparam int SELECTED_REF_SIGNAL_LOSS_BIT = 2;
	localparam int PLL_UNLOCKED_BIT = 3;
	localparam int BUS_TIMEOUT_BIT = 5;
	localparam int REF_SELECT_BY_REGISTER_BIT = 0;
	localparam int REF_SELECT_LSB = 1;
	localparam logic [7:0] FAULT_IMPL_BITS = 8'h2F;
	localparam logic [7:0] INPUT_LOSS_IMPL_BITS = 8'h0F;
	localparam logic [7:0] REF_SELECT_IMPL_BITS = 8'h07;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] MASKS_RESET = 8'h00;
	localparam logic [7:0] REF_SELECT_RESET = 8'h00;

	// ----------------------------------------
	// reference choices
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		REF_CLOCK_INPUT_0 = 2'b00,
		REF_CLOCK_INPUT_1 = 2'b01,
		REF_CLOCK_INPUT_2 = 2'b10,
		REF_CRYSTAL_PIN_PAIR = 2'b11
	} ref_select_t;

	// raw monitor levels from the analog detectors, plus the reference select pins
	typedef struct packed
	{
		logic calibrationActive;
		logic crystalSignalLoss;
		logic pllUnlocked;
		logic busTimeout;
		logic [3:0] perInputSignalLoss;
		logic [1:0] refSelectPins;
	} monitor_t;

	// register access request
	typedef struct packed
	{
		logic write;
		logic read;
		logic [15:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

endpackage

// ==== hdl/fault_status_interrupt.sv ====
// Purpose: live fault status, sticky flags, masks and interrupt pins
// Assumes: monitor levels and select pins are asynchronous to clock
// Notes: register reads answer one cycle after the request
//
// Summary of operation
// - each live condition has its own sticky flag
// - writing zero clears flag, one leaves it
// - calibration running shown at status bit 0
// - crystal loss at bit 1, A pin only
// - selected reference loss at status bit 2
// - pll unlock reported at status bit 3
// - bus timeout reported at status bit 5
// - per-input loss field: in0,in1,in2,feedback
// - flags share the status bit positions
// - irq low while any unmasked flag set
// - mask bit one removes flag from irq
// - status readable; unlock also on own pin
// - reference chosen by pins or register
`timescale 1ns/1ps

module fault_status_interrupt
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// detector levels and select pins
	input wire fault_status_pkg::monitor_t monitorIn,
	// register access
	input wire fault_status_pkg::reg_req_t regReq,
	output logic [7:0] regRdata,
	output logic regRvalid,
	// pins
	output logic irq_out_n,
	output logic unlock_out_n
);
	import fault_status_pkg::*;

	localparam int SYNC_W = $bits(monitor_t);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [SYNC_W-1:0] sync1_r, sync2_r, sync3_r, filt_r, filt_nxt;

	// a level counts only once stages two and three agree
	always_comb
	begin
		filt_nxt = filt_r;
		for (int i = 0; i < SYNC_W; i++)
		begin
			if (sync2_r[i] == sync3_r[i])
				filt_nxt[i] = sync3_r[i];
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
			filt_r <= '0;
		end
		else
		begin
			sync1_r <= monitorIn;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			filt_r <= filt_nxt;
		end
	end

	monitor_t mon;
	assign mon = monitor_t'(filt_r);

	// ----------------------------------------
	// live status
	// ----------------------------------------
	logic [7:0] refSelCtrl_r, refSelCtrl_nxt;
	ref_select_t activeRef;
	logic selectedRefLoss;
	logic [7:0] faultLive, lossLive;

	function automatic logic hit(input reg_req_t r, input logic [15:0] ofs);
		hit = r.write && (r.addr == ofs);
	endfunction

	always_comb
	begin
		if (refSelCtrl_r[REF_SELECT_BY_REGISTER_BIT])
			activeRef = ref_select_t'(refSelCtrl_r[REF_SELECT_LSB +: 2]);
		else
			activeRef = ref_select_t'(mon.refSelectPins);
		case (activeRef)
			REF_CLOCK_INPUT_0: selectedRefLoss = mon.perInputSignalLoss[0];
			REF_CLOCK_INPUT_1: selectedRefLoss = mon.perInputSignalLoss[1];
			REF_CLOCK_INPUT_2: selectedRefLoss = mon.perInputSignalLoss[2];
			REF_CRYSTAL_PIN_PAIR: selectedRefLoss = mon.crystalSignalLoss;
			default: selectedRefLoss = 1'b0;
		endcase
		faultLive = 8'h00;
		faultLive[CALIBRATION_ACTIVE_BIT] = mon.calibrationActive;
		faultLive[CRYSTAL_SIGNAL_LOSS_BIT] = mon.crystalSignalLoss;
		faultLive[SELECTED_REF_SIGNAL_LOSS_BIT] = selectedRefLoss;
		faultLive[PLL_UNLOCKED_BIT] = mon.pllUnlocked;
		faultLive[BUS_TIMEOUT_BIT] = mon.busTimeout;
		lossLive = {4'h0, mon.perInputSignalLoss};
	end

	// ----------------------------------------
	// sticky flags, masks, control
	// ----------------------------------------
	logic [7:0] faultFlags_r, faultFlags_nxt, lossFlags_r, lossFlags_nxt;
	logic [7:0] faultMask_r, faultMask_nxt, lossMask_r, lossMask_nxt;
	logic irqOut_n_r, irqOut_n_nxt, unlockOut_n_r;

	function automatic logic [7:0] sticky(input logic [7:0] flags, input logic [7:0] live,
		input logic clr, input logic [7:0] wdata, input logic [7:0] impl);
		// live term is ORed last so a set wins over a clearing write
		sticky = ((clr ? (flags & wdata) : flags) | live) & impl;
	endfunction

	always_comb
	begin
		faultFlags_nxt = sticky(faultFlags_r, faultLive, hit(regReq, FAULT_STICKY_FLAGS_OFS),
			regReq.wdata, FAULT_IMPL_BITS);
		lossFlags_nxt = sticky(lossFlags_r, lossLive, hit(regReq, INPUT_LOSS_STICKY_FLAGS_OFS),
			regReq.wdata, INPUT_LOSS_IMPL_BITS);
		faultMask_nxt = faultMask_r;
		lossMask_nxt = lossMask_r;
		refSelCtrl_nxt = refSelCtrl_r;
		if (hit(regReq, FAULT_INTERRUPT_MASKS_OFS))
			faultMask_nxt = regReq.wdata & FAULT_IMPL_BITS;
		if (hit(regReq, INPUT_LOSS_INTERRUPT_MASKS_OFS))
			lossMask_nxt = regReq.wdata & INPUT_LOSS_IMPL_BITS;
		if (hit(regReq, REF_SELECT_CTRL_OFS))
			refSelCtrl_nxt = regReq.wdata & REF_SELECT_IMPL_BITS;
		// pin follows the new flag and mask values in the same edge
		irqOut_n_nxt = ~(|(faultFlags_nxt & ~faultMask_nxt) |
			|(lossFlags_nxt & ~lossMask_nxt));
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			faultFlags_r <= FLAGS_RESET;
			lossFlags_r <= FLAGS_RESET;
			faultMask_r <= MASKS_RESET;
			lossMask_r <= MASKS_RESET;
			refSelCtrl_r <= REF_SELECT_RESET;
			irqOut_n_r <= 1'b1;
			unlockOut_n_r <= 1'b1;
		end
		else
		begin
			faultFlags_r <= faultFlags_nxt;
			lossFlags_r <= lossFlags_nxt;
			faultMask_r <= faultMask_nxt;
			lossMask_r <= lossMask_nxt;
			refSelCtrl_r <= refSelCtrl_nxt;
			irqOut_n_r <= irqOut_n_nxt;
			unlockOut_n_r <= ~filt_nxt[$bits(monitor_t) - 3];
		end
	end

	assign irq_out_n = irqOut_n_r;
	assign unlock_out_n = unlockOut_n_r;

	// ----------------------------------------
	// register read
	// ----------------------------------------
	logic [7:0] rdata_r, rdata_nxt;
	logic rvalid_r;

	always_comb
	begin
		case (regReq.addr)
			FAULT_LIVE_STATUS_OFS: rdata_nxt = faultLive;
			INPUT_LOSS_LIVE_STATUS_OFS: rdata_nxt = lossLive;
			FAULT_STICKY_FLAGS_OFS: rdata_nxt = faultFlags_r;
			INPUT_LOSS_STICKY_FLAGS_OFS: rdata_nxt = lossFlags_r;
			FAULT_INTERRUPT_MASKS_OFS: rdata_nxt = faultMask_r;
			INPUT_LOSS_INTERRUPT_MASKS_OFS: rdata_nxt = lossMask_r;
			REF_SELECT_CTRL_OFS: rdata_nxt = refSelCtrl_r;
			default: rdata_nxt = 8'h00;
		endcase
		if (!regReq.read)
			rdata_nxt = rdata_r;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			rvalid_r <= regReq.read;
		end
	end

	assign regRdata = rdata_r;
	assign regRvalid = rvalid_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_flag_sets: assert property (@(posedge clock) disable iff (!rst_b)
		faultLive[PLL_UNLOCKED_BIT] |=> faultFlags_r[PLL_UNLOCKED_BIT])
		else $error("unlock flag did not set");

	chk_flag_clears: assert property (@(posedge clock) disable iff (!rst_b)
		(hit(regReq, INPUT_LOSS_STICKY_FLAGS_OFS) && !regReq.wdata[1] && !lossLive[1])
		|=> !lossFlags_r[1])
		else $error("zero write did not clear flag");

	chk_flag_keeps: assert property (@(posedge clock) disable iff (!rst_b)
		(hit(regReq, FAULT_STICKY_FLAGS_OFS) && regReq.wdata[BUS_TIMEOUT_BIT]
		&& faultFlags_r[BUS_TIMEOUT_BIT]) |=> faultFlags_r[BUS_TIMEOUT_BIT])
		else $error("one write disturbed flag");

	chk_set_wins: assert property (@(posedge clock) disable iff (!rst_b)
		(hit(regReq, FAULT_STICKY_FLAGS_OFS) && faultLive[CALIBRATION_ACTIVE_BIT])
		|=> faultFlags_r[CALIBRATION_ACTIVE_BIT])
		else $error("event lost under clear");

	chk_irq_asserts: assert property (@(posedge clock) disable iff (!rst_b)
		(|(faultFlags_r & ~faultMask_r) || |(lossFlags_r & ~lossMask_r)) |-> !irq_out_n)
		else $error("irq high with pending flag");

	chk_irq_masked: assert property (@(posedge clock) disable iff (!rst_b)
		(faultMask_r == FAULT_IMPL_BITS && lossMask_r == INPUT_LOSS_IMPL_BITS) |-> irq_out_n)
		else $error("masked flags drove irq");

	chk_ref_select: assert property (@(posedge clock) disable iff (!rst_b)
		(refSelCtrl_r[REF_SELECT_BY_REGISTER_BIT] && refSelCtrl_r[REF_SELECT_LSB +: 2] == 2'b10)
		|-> faultLive[SELECTED_REF_SIGNAL_LOSS_BIT] == mon.perInputSignalLoss[2])
		else $error("wrong reference observed");

	chk_unlock_pin: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(mon.pllUnlocked) |-> !unlock_out_n ##1 $past(faultLive[PLL_UNLOCKED_BIT]))
		else $error("unlock pin not low");

	chk_status_read: assert property (@(posedge clock) disable iff (!rst_b)
		(regReq.read && regReq.addr == INPUT_LOSS_LIVE_STATUS_OFS)
		|=> regRvalid && regRdata == {4'h0, $past(mon.perInputSignalLoss)})
		else $error("loss field read wrong");

endmodule

// ==== verification/host_model.sv ====
// Purpose: host on the register port, issues byte reads and writes
// Assumes: requests taken on the rising edge, read answer one cycle later
// Notes: read wait bounded; caller handles a missing answer
`timescale 1ns/1ps

module host_model
	import fault_status_pkg::*;
(
	// clock
	input wire logic clock,
	// register port
	output reg_req_t regReq,
	input wire logic [7:0] regRdata,
	input wire logic regRvalid
);
	initial regReq = '0;

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 regReq = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		#1 regReq = '0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d, output bit ok);
		@(posedge clock);
		#1 regReq = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock);
		#1 regReq = '0;
		ok = 1'b0;
		d = 8'h00;
		for (int n = 0; n < 4 && !ok; n++)
		begin
			if (regRvalid === 1'b1)
			begin
				ok = 1'b1;
				d = regRdata;
			end
			else
			begin
				@(posedge clock);
				#1;
			end
		end
	endtask

	// zero to every flag releases the pin once no live condition holds
	task automatic clearAll();
		wr(FAULT_STICKY_FLAGS_OFS, 8'h00);
		wr(INPUT_LOSS_STICKY_FLAGS_OFS, 8'h00);
	endtask
endmodule

// ==== verification/tb_fault_status_interrupt.sv ====
// Purpose: self-checking bench for fault status and interrupt block
// Assumes: monitor levels settle within 8 clocks
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps

module tb_fault_status_interrupt;
	import fault_status_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	monitor_t mon = '0;
	reg_req_t regReq;
	logic [7:0] regRdata;
	logic regRvalid;
	logic irqN;
	logic unlockN;
	logic [7:0] exp;
	int errTotal = 0;
	int testsRun = 0;

	always #2.5 clock = ~clock;

	fault_status_interrupt dut (.clock(clock), .rst_b(rst_b), .monitorIn(mon),
		.regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid),
		.irq_out_n(irqN), .unlock_out_n(unlockN));
	host_model host (.clock(clock), .regReq(regReq), .regRdata(regRdata),
		.regRvalid(regRvalid));

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
		testsRun++;
		if (got !== e)
		begin
			$display("ERROR %s expected %h seen %h", what, e, got);
			errTotal++;
		end
	endtask

	task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		bit ok;
		host.rd(a, d, ok);
		if (!ok)
		begin
			$display("ERROR regRvalid expected 1 seen 0");
			errTotal++;
			tally_and_finish();
		end
		else
			chk($sformatf("reg %h", a), e, d);
	endtask

	// three sync stages plus filter plus flag edge
	task automatic settle();
		repeat (8) @(posedge clock);
		#1;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (20) @(posedge clock);
		#1 rst_b = 1'b1;
		chk("unlock", 8'h01, {7'h0, unlockN});
		for (int a = 8'h0C; a <= 8'h18; a++)
			rdChk(16'(a), 8'h00);
		chk("irq", 8'h01, {7'h0, irqN});
		$display("reset test done");
		mon = '{1'b1, 1'b1, 1'b1, 1'b1, 4'hA, 2'b00};
		settle();
		rdChk(FAULT_LIVE_STATUS_OFS, 8'h2B);
		rdChk(INPUT_LOSS_LIVE_STATUS_OFS, 8'h0A);
		chk("unlock", 8'h00, {7'h0, unlockN});
		chk("irq", 8'h00, {7'h0, irqN});
		mon.refSelectPins = 2'b01;
		settle();
		rdChk(FAULT_LIVE_STATUS_OFS, 8'h2F);
		for (int s = 0; s < 4; s++)
		begin
			host.wr(REF_SELECT_CTRL_OFS, {5'h00, 2'(s), 1'b1});
			settle();
			exp = (s == 3) ? 8'h2F : (mon.perInputSignalLoss[s] ? 8'h2F : 8'h2B);
			rdChk(FAULT_LIVE_STATUS_OFS, exp);
		end
		$display("live status test done");
		mon = '{1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 2'b00};
		settle();
		rdChk(FAULT_STICKY_FLAGS_OFS, 8'h2F);
		rdChk(INPUT_LOSS_STICKY_FLAGS_OFS, 8'h0A);
		host.wr(FAULT_STICKY_FLAGS_OFS, 8'hF7);
		rdChk(FAULT_STICKY_FLAGS_OFS, 8'h27);
		host.wr(FAULT_STICKY_FLAGS_OFS, 8'h00);
		rdChk(FAULT_STICKY_FLAGS_OFS, 8'h01);
		host.wr(INPUT_LOSS_STICKY_FLAGS_OFS, 8'h02);
		rdChk(INPUT_LOSS_STICKY_FLAGS_OFS, 8'h02);
		host.wr(FAULT_LIVE_STATUS_OFS, 8'h00);
		rdChk(FAULT_LIVE_STATUS_OFS, 8'h01);
		$display("sticky test done");
		host.wr(FAULT_INTERRUPT_MASKS_OFS, 8'hFF);
		chk("irq", 8'h00, {7'h0, irqN});
		host.wr(INPUT_LOSS_INTERRUPT_MASKS_OFS, 8'hFF);
		chk("irq", 8'h01, {7'h0, irqN});
		rdChk(FAULT_INTERRUPT_MASKS_OFS, FAULT_IMPL_BITS);
		rdChk(INPUT_LOSS_INTERRUPT_MASKS_OFS, INPUT_LOSS_IMPL_BITS);
		host.wr(FAULT_INTERRUPT_MASKS_OFS, 8'h00);
		host.wr(INPUT_LOSS_INTERRUPT_MASKS_OFS, 8'h00);
		chk("irq", 8'h00, {7'h0, irqN});
		mon.calibrationActive = 1'b0;
		settle();
		host.clearAll();
		chk("irq", 8'h01, {7'h0, irqN});
		rdChk(FAULT_STICKY_FLAGS_OFS, 8'h00);
		$display("mask test done");
		// ----------------------------------------
		// mid-run reset
		// ----------------------------------------
		host.wr(FAULT_INTERRUPT_MASKS_OFS, 8'hFF);
		mon.pllUnlocked = 1'b1;
		settle();
		chk("unlock", 8'h00, {7'h0, unlockN});
		chk("irq", 8'h01, {7'h0, irqN});
		rst_b = 1'b0;
		repeat (2) @(posedge clock);
		#1 rst_b = 1'b1;
		chk("unlock", 8'h01, {7'h0, unlockN});
		chk("irq", 8'h01, {7'h0, irqN});
		rdChk(FAULT_INTERRUPT_MASKS_OFS, 8'h00);
		settle();
		rdChk(FAULT_LIVE_STATUS_OFS, 8'h08);
		rdChk(FAULT_STICKY_FLAGS_OFS, 8'h08);
		chk("unlock", 8'h00, {7'h0, unlockN});
		chk("irq", 8'h00, {7'h0, irqN});
		mon.pllUnlocked = 1'b0;
		settle();
		chk("unlock", 8'h01, {7'h0, unlockN});
		host.clearAll();
		chk("irq", 8'h01, {7'h0, irqN});
		$display("mid-run reset test done");
		tally_and_finish();
	end
endmodule
